/* File: hdl/csrb_top.sv */
// Notes on behaviour
// [R1] Writing one to start_conversion starts all channels; bit self-clears.
// [R2] Completed reading lands in result registers 64 to 71.
// [R3] Writing one to start_trim_measure starts offset read; bit self-clears.
// [R4] Completed offset reading lands in registers 72 to 75.
// [R5] external_timebase_select high selects the external clock source.
// [R6] Sleep holds only with external clock selected; otherwise cleared.
// [R7] trim_apply_enable high applies measured offsets to channel readings.
// [R8] Each channel has a four-bit capacitor count in low bits.
// [R9] Each channel has 12-bit slot count, low byte and high nibble.
// [R10] Results read as low byte plus high byte bits one and zero.
// [R11] Offset results: sign at bit seven, one negative, seven-bit magnitude.
// [R12] Unavailable bits read zero; writes to them are ignored.
// [R13] Host waits for trigger bit to read zero before reading results.
`timescale 1ns/1ps
`include "csrb_regs.svh"
module csrb_top #(
    // Arbitrary value; strap to the board's chosen bus address
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             scl_pin,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    output logic                  afe_start,
    output logic                  afe_trim_mode,
    input  wire logic             afe_done,
    input  wire logic [3:0][9:0]  afe_sample,
    input  wire logic [3:0][7:0]  afe_trim,
    output logic                  external_timebase_select,
    output logic                  sleep_request,
    output logic                  trim_apply_enable,
    output logic      [3:0][3:0]  gain_capacitors,
    output logic      [3:0][11:0] integration_slots
);
    csrb_pkg::csrb_link_state_t state_reg;
    csrb_pkg::csrb_link_state_t state_next;
    logic [1:0]       pins_s;
    logic             scl_s;
    logic             sda_s;
    logic             scl_d_reg;
    logic             sda_d_reg;
    logic             scl_rise;
    logic             scl_fall;
    logic             start_det;
    logic             stop_det;
    logic [3:0]       cnt_reg;
    logic [3:0]       cnt_next;
    logic [7:0]       shift_reg;
    logic [7:0]       shift_next;
    logic [7:0]       tx_reg;
    logic [7:0]       tx_next;
    logic             oe_next;
    logic [7:0]       ptr_reg;
    logic [7:0]       ptr_next;
    logic             nack_reg;
    logic             nack_next;
    logic             wr_en;
    logic [7:0]       rd_data;
    logic             byte_in;
    logic             conv_trig_reg;
    logic             trim_trig_reg;
    logic             conv_done;
    logic             trim_done;
    logic [3:0][9:0]  sample_reg;
    logic [3:0][7:0]  trim_reg;
    logic             wr_ctrl;
    logic             wr_cfg;
    logic             conv_trig_next;
    logic             trim_trig_next;
    logic             sleep_next;

    function automatic logic addr_hit(input logic       en,
                                      input logic [7:0] a,
                                      input logic [7:0] b);
        return en && (a == b);
    endfunction

    csrb_sync #(.W(2)) u_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in ({scl_pin, sda_in}),
        .sync_out (pins_s)
    );

    csrb_measure u_measure (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .conv_req      (conv_trig_reg),
        .trim_req      (trim_trig_reg),
        .afe_done      (afe_done),
        .afe_start     (afe_start),
        .afe_trim_mode (afe_trim_mode),
        .conv_done     (conv_done),
        .trim_done     (trim_done)
    );

    assign scl_s     = pins_s[1];
    assign sda_s     = pins_s[0];
    assign scl_rise  = scl_s && !scl_d_reg;
    assign scl_fall  = !scl_s && scl_d_reg;
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    assign byte_in   = (cnt_reg == `CSRB_BITS_PER_BYTE);

    // Serial link: bits sampled on rising clock, driven after falling edge
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        tx_next    = tx_reg;
        oe_next    = sda_oe;
        ptr_next   = ptr_reg;
        nack_next  = nack_reg;
        wr_en      = 1'b0;
        if (stop_det)
        begin
            state_next = csrb_pkg::CSRB_LINK_IDLE;
            oe_next    = 1'b0;
        end
        else if (start_det)
        begin
            state_next = csrb_pkg::CSRB_LINK_ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end
        else
        begin
            case (state_reg)
                csrb_pkg::CSRB_LINK_ADDR,
                csrb_pkg::CSRB_LINK_REG,
                csrb_pkg::CSRB_LINK_WDATA:
                begin
                    if (scl_rise && !byte_in)
                    begin
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next   = 4'(cnt_reg + 4'h1);
                    end
                    else if (scl_fall && byte_in)
                    begin
                        cnt_next = 4'h0;
                        oe_next  = 1'b1;
                        if (state_reg == csrb_pkg::CSRB_LINK_ADDR)
                        begin
                            if (shift_reg[7:1] == DEV_ADDR)
                                state_next = csrb_pkg::CSRB_LINK_ADDR_ACK;
                            else
                            begin
                                oe_next    = 1'b0;
                                state_next = csrb_pkg::CSRB_LINK_IDLE;
                            end
                        end
                        else if (state_reg == csrb_pkg::CSRB_LINK_REG)
                        begin
                            ptr_next   = shift_reg;
                            state_next = csrb_pkg::CSRB_LINK_REG_ACK;
                        end
                        else
                        begin
                            wr_en      = 1'b1;
                            state_next = csrb_pkg::CSRB_LINK_WDATA_ACK;
                        end
                    end
                end
                csrb_pkg::CSRB_LINK_ADDR_ACK:
                begin
                    if (scl_fall && shift_reg[0])
                    begin
                        tx_next    = rd_data;
                        oe_next    = !rd_data[7];
                        state_next = csrb_pkg::CSRB_LINK_RDATA;
                    end
                    else if (scl_fall)
                    begin
                        oe_next    = 1'b0;
                        state_next = csrb_pkg::CSRB_LINK_REG;
                    end
                end
                csrb_pkg::CSRB_LINK_REG_ACK,
                csrb_pkg::CSRB_LINK_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_next    = 1'b0;
                        state_next = csrb_pkg::CSRB_LINK_WDATA;
                        if (state_reg == csrb_pkg::CSRB_LINK_WDATA_ACK)
                            ptr_next = 8'(ptr_reg + 8'h01);
                    end
                end
                csrb_pkg::CSRB_LINK_RDATA:
                begin
                    if (scl_rise && !byte_in)
                        cnt_next = 4'(cnt_reg + 4'h1);
                    else if (scl_fall && byte_in)
                    begin
                        cnt_next   = 4'h0;
                        oe_next    = 1'b0;
                        ptr_next   = 8'(ptr_reg + 8'h01);
                        state_next = csrb_pkg::CSRB_LINK_RDATA_ACK;
                    end
                    else if (scl_fall)
                    begin
                        tx_next = {tx_reg[6:0], 1'b0};
                        oe_next = !tx_reg[6];
                    end
                end
                csrb_pkg::CSRB_LINK_RDATA_ACK:
                begin
                    if (scl_rise)
                        nack_next = sda_s;
                    else if (scl_fall && !nack_reg)
                    begin
                        tx_next    = rd_data;
                        oe_next    = !rd_data[7];
                        state_next = csrb_pkg::CSRB_LINK_RDATA;
                    end
                    else if (scl_fall)
                        state_next = csrb_pkg::CSRB_LINK_IDLE;
                end
                default:
                    state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_reg <= csrb_pkg::CSRB_LINK_IDLE;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg    <= 8'h00;
            sda_oe    <= 1'b0;
            sda_out   <= 1'b0;
            ptr_reg   <= 8'h00;
            nack_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            tx_reg    <= tx_next;
            sda_oe    <= oe_next;
            sda_out   <= 1'b0;
            ptr_reg   <= ptr_next;
            nack_reg  <= nack_next;
        end
    end

    assign wr_ctrl = addr_hit(wr_en, ptr_reg, `CSRB_ADDR_CTRL);
    assign wr_cfg  = addr_hit(wr_en, ptr_reg, `CSRB_ADDR_CONFIG);

    // [R1] conversion trigger self-clears
    // A new write of one beats the clearing done pulse
    assign conv_trig_next = (wr_ctrl && shift_reg[`CSRB_BIT_CONV])
                            || (conv_trig_reg && !conv_done);
    // [R3] offset trigger self-clears
    assign trim_trig_next = (wr_ctrl && shift_reg[`CSRB_BIT_TRIM_GO])
                            || (trim_trig_reg && !trim_done);
    // [R6] sleep dropped without external clock
    assign sleep_next = wr_cfg
        ? (shift_reg[`CSRB_BIT_SLEEP] && shift_reg[`CSRB_BIT_EXT_CLK])
        : (sleep_request && external_timebase_select);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            conv_trig_reg            <= `CSRB_RST_BIT;
            trim_trig_reg            <= `CSRB_RST_BIT;
            external_timebase_select <= `CSRB_RST_BIT;
            sleep_request            <= `CSRB_RST_BIT;
            trim_apply_enable        <= `CSRB_RST_BIT;
        end
        else
        begin
            conv_trig_reg <= conv_trig_next;
            trim_trig_reg <= trim_trig_next;
            sleep_request <= sleep_next;
            // [R5] [R7] clock select and trim enable
            if (wr_cfg)
            begin
                external_timebase_select <= shift_reg[`CSRB_BIT_EXT_CLK];
                trim_apply_enable        <= shift_reg[`CSRB_BIT_TRIM_EN];
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_chan
            logic        wr_cap;
            logic        wr_lo;
            logic        wr_hi;
            logic [6:0]  mag;
            logic [10:0] sum;
            logic [10:0] dif;
            logic [9:0]  trimmed;

            assign wr_cap = addr_hit(wr_en, ptr_reg,
                                     8'(`CSRB_ADDR_CAP_BASE + 8'(i)));
            assign wr_lo  = addr_hit(wr_en, ptr_reg,
                                     8'(`CSRB_ADDR_INT_BASE + 8'(2 * i)));
            assign wr_hi  = addr_hit(wr_en, ptr_reg,
                                     8'(`CSRB_ADDR_INT_BASE + 8'(2 * i + 1)));
            assign mag = trim_reg[i][6:0];
            assign sum = {1'b0, afe_sample[i]} + {4'h0, mag};
            assign dif = {1'b0, afe_sample[i]} - {4'h0, mag};
            // [R7] [R11] sign-magnitude offset removed, saturating
            assign trimmed = trim_reg[i][7]
                ? (sum[10] ? 10'h3ff : sum[9:0])
                : (dif[10] ? 10'h000 : dif[9:0]);

            always_ff @(posedge ref_clk)
            begin
                if (!rst_b)
                begin
                    gain_capacitors[i]   <= `CSRB_RST_CAP;
                    integration_slots[i] <= `CSRB_RST_SLOTS;
                    sample_reg[i]        <= `CSRB_RST_SAMPLE;
                    trim_reg[i]          <= `CSRB_RST_TRIM;
                end
                else
                begin
                    // [R8] [R12] capacitor count, upper bits dropped
                    if (wr_cap)
                        gain_capacitors[i] <= shift_reg[3:0];
                    // [R9] slot count halves
                    if (wr_lo)
                        integration_slots[i][7:0] <= shift_reg;
                    if (wr_hi)
                        integration_slots[i][11:8] <= shift_reg[3:0];
                    // [R2] results captured at completion
                    if (conv_done)
                        sample_reg[i] <= trim_apply_enable
                                         ? trimmed : afe_sample[i];
                    // [R4] offsets captured at completion
                    if (trim_done)
                        trim_reg[i] <= afe_trim[i];
                end
            end
        end
    endgenerate

    // [R12] unmapped and unavailable bits read as zero
    always_comb
    begin
        rd_data = 8'h00;
        if (ptr_reg == `CSRB_ADDR_CTRL)
            rd_data = {6'h00, trim_trig_reg, conv_trig_reg};
        else if (ptr_reg == `CSRB_ADDR_CONFIG)
            rd_data = {5'h00, external_timebase_select, sleep_request,
                       trim_apply_enable};
        for (int k = 0; k < 4; k++)
        begin
            if (ptr_reg == 8'(`CSRB_ADDR_CAP_BASE + 8'(k)))
                rd_data = {4'h0, gain_capacitors[k]};
            if (ptr_reg == 8'(`CSRB_ADDR_INT_BASE + 8'(2 * k)))
                rd_data = integration_slots[k][7:0];
            if (ptr_reg == 8'(`CSRB_ADDR_INT_BASE + 8'(2 * k + 1)))
                rd_data = {4'h0, integration_slots[k][11:8]};
            // [R10] ten-bit result split over two bytes
            if (ptr_reg == 8'(`CSRB_ADDR_DATA_BASE + 8'(2 * k)))
                rd_data = sample_reg[k][7:0];
            if (ptr_reg == 8'(`CSRB_ADDR_DATA_BASE + 8'(2 * k + 1)))
                rd_data = {6'h00, sample_reg[k][9:8]};
            if (ptr_reg == 8'(`CSRB_ADDR_TRIM_BASE + 8'(k)))
                rd_data = trim_reg[k];
        end
    end
endmodule // csrb_top

/* File: hdl/csrb_regs.svh */
`ifndef CSRB_REGS_SVH
`define CSRB_REGS_SVH

// Register addresses
`define CSRB_ADDR_CTRL      8'h00
`define CSRB_ADDR_CONFIG    8'h01
`define CSRB_ADDR_CAP_BASE  8'h06
`define CSRB_ADDR_INT_BASE  8'h0a
`define CSRB_ADDR_DATA_BASE 8'h40
`define CSRB_ADDR_TRIM_BASE 8'h48

// Field positions
`define CSRB_BIT_CONV       0
`define CSRB_BIT_TRIM_GO    1
`define CSRB_BIT_TRIM_EN    0
`define CSRB_BIT_SLEEP      1
`define CSRB_BIT_EXT_CLK    2

// Reset values
`define CSRB_RST_CAP        4'hf
`define CSRB_RST_SLOTS      12'h000
`define CSRB_RST_SAMPLE     10'h000
`define CSRB_RST_TRIM       8'h00
`define CSRB_RST_BIT        1'b0

// Serial link bit count per byte
`define CSRB_BITS_PER_BYTE  4'h8

`endif

/* File: hdl/csrb_pkg.sv */
package csrb_pkg;

    typedef enum logic [3:0] {
        CSRB_LINK_IDLE      = 4'b0000,
        CSRB_LINK_ADDR      = 4'b0001,
        CSRB_LINK_ADDR_ACK  = 4'b0010,
        CSRB_LINK_REG       = 4'b0011,
        CSRB_LINK_REG_ACK   = 4'b0100,
        CSRB_LINK_WDATA     = 4'b0101,
        CSRB_LINK_WDATA_ACK = 4'b0110,
        CSRB_LINK_RDATA     = 4'b0111,
        CSRB_LINK_RDATA_ACK = 4'b1000
    } csrb_link_state_t;

    typedef enum logic [1:0] {
        CSRB_MEAS_IDLE = 2'b00,
        CSRB_MEAS_CONV = 2'b01,
        CSRB_MEAS_TRIM = 2'b10
    } csrb_meas_state_t;

endpackage

/* File: hdl/csrb_sync.sv */
`timescale 1ns/1ps
module csrb_sync #(
    parameter int W = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    // Idle-high reset matches a released open-drain line
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            meta_reg <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // csrb_sync

/* File: hdl/csrb_measure.sv */
`timescale 1ns/1ps
module csrb_measure (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic conv_req,
    input  wire logic trim_req,
    input  wire logic afe_done,
    output logic      afe_start,
    output logic      afe_trim_mode,
    output logic      conv_done,
    output logic      trim_done
);
    csrb_pkg::csrb_meas_state_t state_reg;
    csrb_pkg::csrb_meas_state_t state_next;
    logic                       launch_ok;
    logic                       go_conv;
    logic                       go_trim;

    // Requests stay high until the done pulse clears them one cycle later
    assign launch_ok = (state_reg == csrb_pkg::CSRB_MEAS_IDLE)
                       && !conv_done && !trim_done;
    assign go_conv = launch_ok && conv_req;
    assign go_trim = launch_ok && !conv_req && trim_req;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            csrb_pkg::CSRB_MEAS_IDLE:
            begin
                if (go_conv)
                    state_next = csrb_pkg::CSRB_MEAS_CONV;
                else if (go_trim)
                    state_next = csrb_pkg::CSRB_MEAS_TRIM;
            end
            csrb_pkg::CSRB_MEAS_CONV,
            csrb_pkg::CSRB_MEAS_TRIM:
            begin
                if (afe_done)
                    state_next = csrb_pkg::CSRB_MEAS_IDLE;
            end
            default:
                state_next = csrb_pkg::CSRB_MEAS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_reg     <= csrb_pkg::CSRB_MEAS_IDLE;
            afe_start     <= 1'b0;
            afe_trim_mode <= 1'b0;
            conv_done     <= 1'b0;
            trim_done     <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            afe_start     <= go_conv || go_trim;
            afe_trim_mode <= go_trim ? 1'b1 : (go_conv ? 1'b0 : afe_trim_mode);
            conv_done     <= afe_done
                             && (state_reg == csrb_pkg::CSRB_MEAS_CONV);
            trim_done     <= afe_done
                             && (state_reg == csrb_pkg::CSRB_MEAS_TRIM);
        end
    end
endmodule // csrb_measure

/* File: tb/csrb_top_monitor.sv */
`timescale 1ns/1ps
module csrb_top_monitor (
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    input wire logic              afe_start,
    input wire logic              afe_trim_mode,
    input wire logic              afe_done,
    input wire logic              external_timebase_select,
    input wire logic              sleep_request,
    input wire logic              trim_apply_enable,
    input wire logic  [3:0][3:0]  gain_capacitors,
    input wire logic  [3:0][11:0] integration_slots
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_out_of_reset;
        $rose(rst_b);
    endsequence
    sequence s_run_go;
        afe_start;
    endsequence
    sequence s_oe_on;
        $rose(sda_oe);
    endsequence
    sequence s_oe_off;
        $fell(sda_oe);
    endsequence
    a_sda_only_low: assert property (sda_out == 1'b0)
        else $error("serial data driven high");
    a_sleep_needs_ext: assert property (sleep_request |->
        external_timebase_select)
        else $error("sleep held without external clock");
    a_gain_reset_value: assert property (s_out_of_reset |->
        gain_capacitors == {4{4'hf}})
        else $error("capacitor count not at reset value");
    a_slots_reset_zero: assert property (s_out_of_reset |->
        integration_slots == '0 && !sda_oe && !trim_apply_enable)
        else $error("slot count or mode not clear after reset");
    // mode only moves with a start
    a_trim_mode_hold: assert property (!afe_start |->
        $stable(afe_trim_mode))
        else $error("measurement mode changed without start");
    a_single_run_start: assert property (s_run_go |=>
        !afe_start until afe_done)
        else $error("measurement restarted before completion");
    // driven bit stands a whole phase
    a_oe_rise_holds: assert property (s_oe_on |-> sda_oe [*4])
        else $error("acknowledge dropped too early");
    a_oe_fall_holds: assert property (s_oe_off |-> !sda_oe [*4])
        else $error("serial data released too briefly");
endmodule // csrb_top_monitor

bind csrb_top csrb_top_monitor csrb_top_monitor_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .sda_out(sda_out), .sda_oe(sda_oe),
    .afe_start(afe_start), .afe_trim_mode(afe_trim_mode),
    .afe_done(afe_done),
    .external_timebase_select(external_timebase_select),
    .sleep_request(sleep_request), .trim_apply_enable(trim_apply_enable),
    .gain_capacitors(gain_capacitors),
    .integration_slots(integration_slots)
);

/* File: tb/csrb_host_model.sv */
`timescale 1ns/1ps
module csrb_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Clock stands high between frames
    task automatic start();
        #50 sda_pull = 1'b1;
        #100 scl = 1'b0;
    endtask
    task automatic stop();
        #50 sda_pull = 1'b1;
        #50 scl = 1'b1;
        #100 sda_pull = 1'b0;
        #100;
    endtask
    // Sample late in the high phase; device answers ~75 ns after fall
    task automatic clk_bit(input logic b, output logic r);
        #50 sda_pull = !b;
        #50 scl = 1'b1;
        #95 r = sda;
        #5 scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            clk_bit(tx[i], rx[i]);
        clk_bit(ack_in, ack);
    endtask
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] rx;
        logic       ack;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx, ack);
        xfer(ptr, 1'b1, rx, ack);
        xfer(d, 1'b1, rx, ack);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
        logic [7:0] rx;
        logic       ack;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx, ack);
        xfer(ptr, 1'b1, rx, ack);
        stop();
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, rx, ack);
        // Not acknowledging ends the read
        xfer(8'hff, 1'b1, d, ack);
        stop();
    endtask
endmodule // csrb_host_model

/* File: tb/tb_color_sensor_register_bank.sv */
`timescale 1ns/1ps
module tb_color_sensor_register_bank;
    logic             ref_clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             scl, pull, sda_out, sda_oe, afe_start, afe_mode;
    logic             afe_done = 1'b0;
    logic             ext_sel, sleep_req, trim_en;
    logic [3:0][9:0]  samp = '0;
    logic [3:0][7:0]  trim = '0;
    logic [3:0][3:0]  gain;
    logic [3:0][11:0] slots;
    logic [7:0]       d;
    int               errors = 0;
    int               n_compared = 0;
    wire              sda = !(pull | sda_oe);

    always #12.5 ref_clk = !ref_clk;

    csrb_top csrb_top_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .scl_pin(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .afe_start(afe_start),
        .afe_trim_mode(afe_mode), .afe_done(afe_done), .afe_sample(samp),
        .afe_trim(trim), .external_timebase_select(ext_sel),
        .sleep_request(sleep_req), .trim_apply_enable(trim_en),
        .gain_capacitors(gain), .integration_slots(slots));
    csrb_host_model csrb_host_model_i (
        .sda(sda), .scl(scl), .sda_pull(pull));

    // Front end answers five cycles after a start
    always @(posedge ref_clk)
        if (afe_start === 1'b1)
        begin
            repeat (5) @(posedge ref_clk);
            #1 afe_done = 1'b1;
            @(posedge ref_clk);
            #1 afe_done = 1'b0;
        end

    task automatic check(input string name, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        csrb_host_model_i.write_reg(a, v);
    endtask
    task automatic rd(input logic [7:0] a);
        csrb_host_model_i.read_reg(a, d);
    endtask
    // results read only once trigger bit is back to zero
    task automatic wait_idle(input int b);
        for (int n = 0; n < 20; n++)
        begin
            rd(8'h00);
            if (d[b] === 1'b0)
                return;
        end
        errors++;
        conclude();
    endtask
    task automatic t_reset();
        rd(8'h06);
        check("cap read", d, 16'h000f);
        check("cap port", gain, 16'hffff);
        rd(8'h0b);
        check("slot high", d, 16'h0000);
        rd(8'h01);
        check("config", d, 16'h0000);
    endtask
    task automatic t_fields();
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h06 + 8'(i), {4'hf, 4'(i + 3)});
            rd(8'h06 + 8'(i));
            check("cap", d, 16'(i + 3));
            check("cap port", gain[i], 16'(i + 3));
            wr(8'h0a + 8'(2 * i), 8'h5a + 8'(i));
            wr(8'h0b + 8'(2 * i), 8'hf1 + 8'(i));
            rd(8'h0b + 8'(2 * i));
            check("slot high", d, 16'(i + 1));
            check("slot port", slots[i], {4'h0, 4'(i + 1), 8'h5a + 8'(i)});
        end
    endtask
    task automatic t_conv();
        samp = {10'h3ff, 10'h200, 10'h155, 10'h001};
        wr(8'h00, 8'h01);
        wait_idle(0);
        for (int i = 0; i < 8; i++)
        begin
            rd(8'h40 + 8'(i));
            check("sample", d, i[0] ? 16'(samp[i / 2][9:8])
                                    : 16'(samp[i / 2][7:0]));
        end
        check("sample end", d, 16'h0003);
    endtask
    task automatic t_trim();
        trim = {8'h85, 8'h7f, 8'h80, 8'h05};
        wr(8'h00, 8'h02);
        wait_idle(1);
        check("afe mode", afe_mode, 16'h0001);
        for (int i = 0; i < 4; i++)
        begin
            rd(8'h48 + 8'(i));
            check("offset", d, 16'(trim[i]));
        end
        check("offset sign", d[7], 16'h0001);
    endtask
    task automatic t_config();
        wr(8'h01, 8'hff);
        rd(8'h01);
        check("config", d, 16'h0007);
        check("mode pins", {ext_sel, sleep_req, trim_en}, 16'h0007);
        wr(8'h01, 8'h03);
        rd(8'h01);
        check("sleep drop", d, 16'h0001);
        samp[0] = 10'h100;
        wr(8'h00, 8'h01);
        wait_idle(0);
        rd(8'h40);
        check("trimmed", d, 16'h00fb);
        check("afe mode", afe_mode, 16'h0000);
    endtask
    task automatic t_refuse();
        wr(8'h40, 8'h55);
        rd(8'h40);
        check("read only", d, 16'h00fb);
        rd(8'h20);
        check("unmapped", d, 16'h0000);
        wr(8'h00, 8'hfc);
        rd(8'h00);
        check("ctrl spare", d, 16'h0000);
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        // Host pin edges must not race the synchroniser's clock edge
        #1;
        t_reset();
        t_fields();
        t_conv();
        t_trim();
        t_config();
        t_refuse();
        conclude();
    end
endmodule // tb_color_sensor_register_bank
